// >>> nand_lock_pkg.sv
// Purpose: Shared constants for the NAND status and block-lock host controller
// Assumes: Single clock mclk at 40 MHz, synchronous active-low reset
// Notes:   Opcodes and timings are plain parameters where not documented
package nand_lock_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_STROBE_NS   = 50;
  localparam int unsigned STROBE_CYC    =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OP_UNLOCK_LO   = 8'h23;
  localparam logic [7:0] OP_UNLOCK_HI   = 8'h24;
  localparam logic [7:0] OP_STATUS      = 8'h70;
  localparam logic [7:0] OP_LOCK_STATUS = 8'h7A;
  localparam logic [7:0] OP_LOCK        = 8'h2A;
  localparam logic [7:0] OP_LOCK_TIGHT  = 8'h2C;
  localparam int unsigned SR_FAIL     = 0;
  localparam int unsigned SR_PFAIL    = 1;
  localparam int unsigned SR_REWRITE  = 3;
  localparam int unsigned SR_ALL_OPS_READY_BIT     = 5;
  localparam int unsigned SR_RDY      = 6;
  localparam int unsigned SR_WPN      = 7;
  localparam int unsigned LS_TIGHT    = 0;
  localparam int unsigned LS_TIGHT_N  = 1;
  localparam int unsigned LS_LOCKED_N = 2;
  localparam int unsigned INV_BIT     = 0;
  localparam int unsigned UID_HALF    = 16;
  localparam int unsigned UID_COPIES  = 16;
  localparam int unsigned UID_BYTES   = 32;
  typedef enum logic [1:0] {
    CYC_CMD  = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_RD   = 2'b11,
    CYC_WR   = 2'b10
  } cyc_kind_t;
endpackage

// >>> nand_bus_cycle.sv
// Purpose: One asynchronous NAND bus cycle with a timed strobe
// Assumes: Pin inputs synchronous to mclk
// Notes:   Write data latched by device on rising write strobe
module nand_bus_cycle
  import nand_lock_pkg::*;
#(
  parameter int unsigned STROBE = STROBE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Request
  input  wire logic        start,
  input  wire cyc_kind_t   kind,
  input  wire logic [7:0]  wrData,
  output logic             done,
  output logic [7:0]       rdData,
  // Pins
  output logic             cle,
  output logic             ale,
  output logic             weN,
  output logic             reN,
  output logic [7:0]       ioOut,
  output logic             ioOe,
  input  wire logic [7:0]  ioIn
);
  logic [7:0] cnt_q;
  logic       busy_q;
  logic       isRd;
  logic       last;
  assign isRd = (kind == CYC_RD);
  assign last = busy_q && (cnt_q == 8'(STROBE));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      done   <= 1'b0;
      rdData <= 8'h00;
      cle    <= 1'b0;
      ale    <= 1'b0;
      weN    <= 1'b1;
      reN    <= 1'b1;
      ioOut  <= 8'h00;
      ioOe   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= 8'h01;
        cle    <= (kind == CYC_CMD);
        ale    <= (kind == CYC_ADDR);
        weN    <= isRd;
        reN    <= !isRd;
        ioOut  <= isRd ? 8'h00 : wrData;
        ioOe   <= !isRd;
      end else if (last) begin
        // Sample read data just before releasing the read strobe
        if (!reN) rdData <= ioIn;
        busy_q <= 1'b0;
        weN    <= 1'b1;
        reN    <= 1'b1;
        done   <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 8'h01;
      end else begin
        cle  <= 1'b0;
        ale  <= 1'b0;
        ioOe <= 1'b0;
      end
    end
  end
endmodule

// >>> nand_lock_host.sv
// Purpose: Host side of NAND status reads and block-range write protection
// Assumes: Device pins sampled synchronously; one order at a time
// Notes:   Unique-ID copies checked locally after the user streams them in
//
// Summary of operation
// - Host XOR-checks each ID copy, moving on until one passes or 16 copies have failed.
// - After write guard pulse, host must unlock again before writing.
// - Host programs lower boundary strictly below upper boundary.
// - Three boundary address cycles; unused lines driven low by host.
module nand_lock_host
  import nand_lock_pkg::*;
#(
  parameter int unsigned BA_W = 18
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // User orders
  input  wire logic            unlockReq,
  input  wire logic [BA_W-1:0] lowerBlock,
  input  wire logic [BA_W-1:0] upperBlock,
  input  wire logic            invert,
  input  wire logic            statusReq,
  input  wire logic            lockStatReq,
  input  wire logic [BA_W-1:0] queryBlock,
  input  wire logic            guardReq,
  input  wire logic            guardLevel,
  output logic                 busy,
  output logic                 orderDone,
  output logic                 orderErr,
  // Status results
  output logic [7:0]           statusByte,
  output logic                 devReady,
  output logic                 allReady,
  output logic                 opFail,
  output logic                 prevFail,
  output logic                 rewriteAdv,
  output logic [2:0]           lockState,
  output logic                 needUnlock,
  // Unique-ID check stream
  input  wire logic            uidValid,
  input  wire logic [7:0]      uidByte,
  output logic                 uidGood,
  output logic                 uidDone,
  // Device pins
  output logic                 ceN,
  output logic                 cle,
  output logic                 ale,
  output logic                 weN,
  output logic                 reN,
  output logic                 writeGuardN,
  output logic [7:0]           ioOut,
  output logic                 ioOe,
  input  wire logic [7:0]      ioIn,
  input  wire logic            readyBusyN
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD  = 3'b001,
    S_A1   = 3'b011,
    S_A2   = 3'b010,
    S_A3   = 3'b110,
    S_RD   = 3'b111,
    S_FIN  = 3'b100
  } state_t;

  state_t          st_q;
  logic [1:0]      op_q;
  logic            hiPass_q;
  logic [BA_W-1:0] ba_q;
  logic            inv_q;
  logic            cycStart_q;
  cyc_kind_t       cycKind_q;
  logic [7:0]      cycData_q;
  logic            cycDone;
  logic [7:0]      cycRd;
  logic [7:0]      a1;
  logic [7:0]      a2;
  logic [7:0]      a3;
  logic            rangeBad;
  logic [7:0]      opcode;

  assign a1 = {ba_q[7:6], 5'h00, hiPass_q & inv_q};
  assign a2 = ba_q[15:8];
  assign a3 = {6'h00, ba_q[17:16]};
  assign rangeBad = !(lowerBlock < upperBlock);
  assign opcode = (op_q == 2'd1) ? OP_STATUS :
                  (op_q == 2'd2) ? OP_LOCK_STATUS :
                  hiPass_q ? OP_UNLOCK_HI : OP_UNLOCK_LO;

  nand_bus_cycle u_cyc (
    .mclk   (mclk),
    .resetn (resetn),
    .start  (cycStart_q),
    .kind   (cycKind_q),
    .wrData (cycData_q),
    .done   (cycDone),
    .rdData (cycRd),
    .cle    (cle),
    .ale    (ale),
    .weN    (weN),
    .reN    (reN),
    .ioOut  (ioOut),
    .ioOe   (ioOe),
    .ioIn   (ioIn)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= S_IDLE; op_q <= 2'd0; hiPass_q <= 1'b0;
      ba_q <= '0; inv_q <= 1'b0;
      cycStart_q <= 1'b0; cycKind_q <= CYC_CMD; cycData_q <= 8'h00;
      busy <= 1'b0; orderDone <= 1'b0; orderErr <= 1'b0;
      statusByte <= 8'h00; lockState <= 3'b000;
      writeGuardN <= 1'b0; needUnlock <= 1'b1; ceN <= 1'b1;
    end else begin
      cycStart_q <= 1'b0;
      orderDone  <= 1'b0;
      orderErr   <= 1'b0;
      case (st_q)
        S_IDLE: begin
          ceN  <= 1'b1;
          busy <= 1'b0;
          if (guardReq) begin
            // rising guard after low still needs a fresh unlock
            if (!guardLevel) needUnlock <= 1'b1;
            writeGuardN <= guardLevel;
            orderDone <= 1'b1;
          end else if (unlockReq && rangeBad) begin
            orderErr <= 1'b1;
          end else if (unlockReq || statusReq || lockStatReq) begin
            op_q <= unlockReq ? 2'd0 : statusReq ? 2'd1 : 2'd2;
            hiPass_q <= 1'b0;
            ba_q <= unlockReq ? lowerBlock : queryBlock;
            inv_q <= invert;
            busy <= 1'b1; ceN <= 1'b0;
            st_q <= S_CMD;
          end
        end
        S_CMD: begin
          cycStart_q <= 1'b1; cycKind_q <= CYC_CMD; cycData_q <= opcode;
          st_q <= S_A1;
        end
        S_A1: if (cycDone) begin
          cycStart_q <= 1'b1;
          cycKind_q <= (op_q == 2'd1) ? CYC_RD : CYC_ADDR;
          cycData_q <= a1;
          st_q <= (op_q == 2'd1) ? S_RD : S_A2;
        end
        S_A2: if (cycDone) begin
          cycStart_q <= 1'b1; cycKind_q <= CYC_ADDR; cycData_q <= a2;
          st_q <= S_A3;
        end
        S_A3: if (cycDone) begin
          cycStart_q <= 1'b1; cycKind_q <= CYC_ADDR; cycData_q <= a3;
          st_q <= (op_q == 2'd2) ? S_RD : S_FIN;
        end
        S_RD: if (cycDone) begin
          // Lock status needs one extra read after its address
          if (op_q == 2'd2 && cycKind_q != CYC_RD) begin
            cycStart_q <= 1'b1; cycKind_q <= CYC_RD;
          end else begin
            if (op_q == 2'd1) statusByte <= cycRd;
            else lockState <= cycRd[2:0];
            st_q <= S_FIN;
          end
        end
        S_FIN: begin
          if (op_q != 2'd0 || cycDone) begin
            if (op_q == 2'd0 && !hiPass_q) begin
              // lower done, now the upper pass
              hiPass_q <= 1'b1; ba_q <= upperBlock; st_q <= S_CMD;
            end else begin
              if (op_q == 2'd0) needUnlock <= 1'b0;
              orderDone <= 1'b1; st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Status fields; ready mirrors the pin every cycle, one cycle late
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      devReady <= 1'b0; allReady <= 1'b0; opFail <= 1'b0;
      prevFail <= 1'b0; rewriteAdv <= 1'b0;
    end else begin
      devReady   <= readyBusyN;
      allReady   <= statusByte[SR_ALL_OPS_READY_BIT];
      opFail     <= statusByte[SR_FAIL];
      prevFail   <= statusByte[SR_PFAIL];
      rewriteAdv <= statusByte[SR_REWRITE];
    end
  end

  // ID copy check, each byte of first half XOR its complement
  logic [7:0] idHalf_q [UID_HALF];
  logic [4:0] pos_q;
  logic [4:0] copy_q;
  logic       ok_q;
  logic       isHi;
  logic       match;
  assign isHi  = pos_q[4];
  assign match = ((idHalf_q[pos_q[3:0]] ^ uidByte) == 8'hFF);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pos_q <= 5'd0; copy_q <= 5'd0; ok_q <= 1'b1;
      uidGood <= 1'b0; uidDone <= 1'b0;
    end else if (uidValid && !uidGood && !uidDone) begin
      if (!isHi) idHalf_q[pos_q[3:0]] <= uidByte;
      else if (!match) ok_q <= 1'b0;
      pos_q <= pos_q + 5'd1;
      if (pos_q == 5'(UID_BYTES - 1)) begin
        if (ok_q && match) uidGood <= 1'b1;
        else if (copy_q == 5'(UID_COPIES - 1)) uidDone <= 1'b1;
        copy_q <= copy_q + 5'd1;
        ok_q <= 1'b1;
      end
    end
  end

  property p_unlock_pair;
    @(posedge mclk) disable iff (!resetn)
      (st_q == S_FIN && op_q == 2'd0 && !hiPass_q && cycDone)
      |=> (hiPass_q && st_q == S_CMD);
  endproperty
  a_unlock_pair: assert property (p_unlock_pair)
    else $error("upper boundary pass did not follow lower");

  property p_inv_lo;
    @(posedge mclk) disable iff (!resetn)
      (cycStart_q && cycKind_q == CYC_ADDR && st_q == S_A2 && !hiPass_q
       && op_q == 2'd0) |-> !cycData_q[INV_BIT];
  endproperty
  a_inv_lo: assert property (p_inv_lo)
    else $error("invert bit sent with lower boundary");

  property p_bad_range;
    @(posedge mclk) disable iff (!resetn)
      (st_q == S_IDLE && !guardReq && unlockReq && rangeBad)
      |=> (orderErr && st_q == S_IDLE);
  endproperty
  a_bad_range: assert property (p_bad_range)
    else $error("bad boundary order was not refused");

  property p_guard;
    @(posedge mclk) disable iff (!resetn)
      (st_q == S_IDLE && guardReq && !guardLevel) |=> needUnlock;
  endproperty
  a_guard: assert property (p_guard)
    else $error("guard pulse did not demand unlock");
endmodule

// >>> nand_dev_model.sv
// Purpose: Behavioural device facing the lock host in the bench
// Assumes: Pins move only just after mclk edges
// Notes:   Tight lock and array writes are not modelled
module nand_dev_model
  import nand_lock_pkg::*;
#(
  parameter bit STRAP = 1'b1
) (
  // Device pins
  input  wire logic        ceN,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        weN,
  input  wire logic        reN,
  input  wire logic        writeGuardN,
  input  wire logic [7:0]  ioOut,
  output logic [7:0]       ioIn,
  output logic             readyBusyN,
  // Bench view
  input  wire logic [7:0]  statusVal,
  output logic [17:0]      lowerQ,
  output logic [17:0]      upperQ,
  output logic             invQ,
  output logic             badAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cmdQ;
  logic [7:0]  outByte;
  logic [17:0] ba;
  logic        inv;
  logic        lockAll;
  logic        inRange;
  int          na;
  assign readyBusyN = statusVal[6];
  // Undriven bus shows no stale byte
  assign ioIn = (!ceN && !reN) ? outByte : ~outByte;
  initial begin
    lockAll = STRAP;
    {lowerQ, upperQ, invQ, badAddr, na, cmdQ, outByte, ba} = '0;
  end
  always @(negedge writeGuardN) lockAll = STRAP;
  always @(posedge weN) begin
    if (!ceN && cle) begin
      cmdQ = ioOut;
      na = 0;
      outByte = {writeGuardN, statusVal[6:0]};
    end else if (!ceN && ale) begin
      case (na)
        0: begin
          ba[7:6] = ioOut[7:6];
          inv = ioOut[0];
          badAddr |= |ioOut[5:1];
        end
        1: ba[15:8] = ioOut;
        default: begin
          ba[17:16] = ioOut[1:0];
          badAddr |= |ioOut[7:2];
        end
      endcase
      ba[5:0] = 6'h00;
      na++;
      if (na == 3 && STRAP && cmdQ == OP_UNLOCK_LO) lowerQ = ba;
      if (na == 3 && STRAP && cmdQ == OP_UNLOCK_HI) begin
        upperQ = ba;
        invQ = inv;
        lockAll = 1'b0;
      end
      if (na == 3 && cmdQ == OP_LOCK_STATUS) begin
        inRange = ba >= lowerQ && ba <= upperQ;
        outByte = 8'h02;
        if (!STRAP || (!lockAll && writeGuardN && (invQ ^ inRange)))
          outByte = 8'h06;
      end
    end
  end
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the NAND lock host
// Assumes: Device model answers every bus cycle at once
// Notes:   Expected values come from a small model in the bench
module tb
  import nand_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, unlockReq, invert, statusReq, lockStatReq;
  logic guardReq, guardLevel, uidValid, busy, orderDone, orderErr;
  logic devReady, allReady, opFail, prevFail, rewriteAdv, needUnlock;
  logic uidGood, uidDone, ceN, cle, ale, weN, reN, writeGuardN, ioOe;
  logic readyBusyN, invQ, badAddr, lastErr;
  logic [17:0] lowerBlock, upperBlock, queryBlock, lowerQ, upperQ;
  logic [7:0]  uidByte, statusVal, statusByte, ioOut, ioIn;
  logic [2:0]  lockState;
  int failures, cmpCount, seed, lo, hi, q, i, unl;
  logic [7:0]  sv;
  logic        sawBusy;

  nand_lock_host dut (
    .mclk(mclk), .resetn(resetn), .unlockReq(unlockReq),
    .lowerBlock(lowerBlock), .upperBlock(upperBlock), .invert(invert),
    .statusReq(statusReq), .lockStatReq(lockStatReq),
    .queryBlock(queryBlock), .guardReq(guardReq), .guardLevel(guardLevel),
    .busy(busy), .orderDone(orderDone), .orderErr(orderErr),
    .statusByte(statusByte), .devReady(devReady), .allReady(allReady),
    .opFail(opFail), .prevFail(prevFail), .rewriteAdv(rewriteAdv),
    .lockState(lockState), .needUnlock(needUnlock),
    .uidValid(uidValid), .uidByte(uidByte), .uidGood(uidGood),
    .uidDone(uidDone), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
    .reN(reN), .writeGuardN(writeGuardN), .ioOut(ioOut), .ioOe(ioOe),
    .ioIn(ioIn), .readyBusyN(readyBusyN)
  );
  nand_dev_model model (
    .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
    .writeGuardN(writeGuardN), .ioOut(ioOut), .ioIn(ioIn),
    .readyBusyN(readyBusyN), .statusVal(statusVal), .lowerQ(lowerQ),
    .upperQ(upperQ), .invQ(invQ), .badAddr(badAddr)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d failures", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One order, then wait for its end under a bound
  task automatic go(input int k);
    int n;
    @(posedge mclk);
    case (k)
      0: guardReq <= 1'b1;
      1: unlockReq <= 1'b1;
      2: statusReq <= 1'b1;
      default: lockStatReq <= 1'b1;
    endcase
    @(posedge mclk);
    {guardReq, unlockReq, statusReq, lockStatReq} <= 4'h0;
    n = 0;
    sawBusy = 1'b0;
    while (orderDone !== 1'b1 && orderErr !== 1'b1 && n < 400) begin
      sawBusy = sawBusy | busy;
      @(posedge mclk);
      n++;
    end
    lastErr = orderErr;
    if (n == 400) failures++;
    repeat (2) @(posedge mclk);
  endtask

  task automatic query(input int blk);
    int inRange;
    queryBlock <= 18'(blk << 6);
    go(3);
    inRange = blk >= lo && blk <= hi;
    if (unl != 0 && guardLevel && (invert ^ inRange))
      chk("lockState", lockState, 3'b110);
    else
      chk("lockState", lockState, 3'b010);
  endtask

  task automatic unlock(input int l, input int h, input logic iv);
    lowerBlock <= 18'(l << 6);
    upperBlock <= 18'(h << 6);
    invert <= iv;
    go(1);
    chk("busy", sawBusy, l < h);
    if (l < h) unl = 1;
  endtask

  task automatic status(input logic gl);
    sv = 8'($random(seed));
    statusVal <= sv;
    go(2);
    chk("statusByte", statusByte, {gl, sv[6:0]});
    chk("flags", {allReady, opFail, prevFail, rewriteAdv},
        {sv[5], sv[0], sv[1], sv[3]});
    chk("devReady", devReady, sv[6]);
  endtask

  task automatic uidCopy(input logic bad);
    for (int j = 0; j < 32; j++) begin
      @(posedge mclk);
      uidValid <= 1'b1;
      uidByte <= (bad && j == 20) ? 8'(j * 37) :
                 (j < 16) ? 8'(j * 37) : ~8'((j - 16) * 37);
    end
    @(posedge mclk);
    uidValid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    {resetn, unlockReq, invert, statusReq, lockStatReq, uidValid} = '0;
    {guardReq, guardLevel, lastErr, lowerBlock, upperBlock} = '0;
    {queryBlock, uidByte, statusVal, failures, cmpCount} = '0;
    seed = 82825;
    lo = 0;
    hi = 0;
    unl = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk("needUnlock", needUnlock, 1'b1);
    chk("idle", {ceN, weN, reN, ioOe, busy}, 5'b11100);
    status(1'b0);
    guardLevel <= 1'b1;
    go(0);
    chk("guard", writeGuardN, 1'b1);
    query(5);
    $display("reset and guard test done");
    for (i = 0; i < 4; i++) status(1'b1);
    $display("status test done");
    for (i = 0; i < 4; i++) begin
      lo = $random(seed) & 'h7FF;
      hi = lo + 1 + ($random(seed) & 'h3F);
      unlock(lo, hi, i[0]);
      chk("lower", lowerQ, 18'(lo << 6));
      chk("upper", upperQ, 18'(hi << 6));
      chk("invert", invQ, i[0]);
      chk("addrLow", badAddr, 1'b0);
      chk("needUnlock", needUnlock, 1'b0);
      query(lo);
      query(hi);
      query(hi + 1);
    end
    unlock(hi, hi, 1'b0);
    chk("refused", lastErr, 1'b1);
    chk("lowerKept", lowerQ, 18'(lo << 6));
    $display("unlock test done");
    guardLevel <= 1'b0;
    go(0);
    unl = 0;
    chk("needUnlock", needUnlock, 1'b1);
    query(lo);
    guardLevel <= 1'b1;
    go(0);
    query(lo);
    unlock(lo, hi, 1'b0);
    query(lo);
    $display("guard test done");
    uidCopy(1'b1);
    chk("uidBad", uidGood, 1'b0);
    uidCopy(1'b0);
    chk("uidGood", uidGood, 1'b1);
    chk("uidDone", uidDone, 1'b0);
    $display("unique id test done");
    print_verdict();
  end

  initial begin
    #500_000;
    failures++;
    print_verdict();
  end
endmodule
